//--- shared/pgm_consts.vh
// constants for the power-good and overload monitor
`ifndef PGM_CONSTS_VH
`define PGM_CONSTS_VH
`define PGM_CLK_MHZ 20
`define PGM_GATE_US 800
// cycle counts below are the microsecond figures times the clock in MHz
`define PGM_GATE_CYC 16'h3e80
`define PGM_BUCK_ILIM_US 20
`define PGM_BUCK_ILIM_CYC 16'h0190
`define PGM_BOOST_CURRENT_LIMIT_SETTING_US 64
`define PGM_BOOST_CURRENT_LIMIT_SETTING_CYC 16'h0500
`define PGM_QUAL_MS 1
`define PGM_QUAL_CYC 16'h4e20
`define PGM_DEB_CYC 16'h0014
`define PGM_CW 16
// apb map, byte addresses
`define PGM_A_CTRL 12'h000
`define PGM_A_FLAGS 12'h004
`define PGM_A_STAT 12'h008
`define PGM_A_PGF 12'h00c
// flags register bit positions
`define PGM_F_B1SC 0
`define PGM_F_B2SC 1
`define PGM_F_BSTSC 2
`define PGM_F_B1IL 3
`define PGM_F_B2IL 4
`define PGM_F_BSTIL 5
`define PGM_F_TSD 6
`define PGM_F_OVP 7
`define PGM_F_RST 8
`define PGM_NFLAG 9
`define PGM_NRAIL 3
`define PGM_CTRL_RST 16'h0000
`endif

//--- rtl/pgm_timer.v
// qualification counter: output high after condition held for LIMIT cycles
`timescale 1ns/1ps
`include "pgm_consts.vh"
module pgm_timer #(
   parameter [`PGM_CW-1:0] LIMIT = 16'h0001
) (
   // clock and reset
   input wire CORE_CLK,
   input wire RESET_N,
   // condition and result
   input wire COND,
   output wire DONE
);
   reg [`PGM_CW-1:0] cnt_reg;
   reg [`PGM_CW-1:0] cnt_next;
   always @* begin
      cnt_next = cnt_reg;
      if (!COND) begin
         cnt_next = {`PGM_CW{1'b0}};
      end else if (cnt_reg != LIMIT) begin
         cnt_next = cnt_reg + 16'h0001;
      end
   end
   always @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         cnt_reg <= {`PGM_CW{1'b0}};
      end else begin
         cnt_reg <= cnt_next;
      end
   end
   assign DONE = COND && (cnt_reg == LIMIT);
endmodule

//--- rtl/pgm_monitor.v
// power-good and overload monitor with apb register access
//
// What this block does
// - power-good low until standby reached
// - unselected rail always counts acceptable
// - disabled rail counts acceptable unless its short flag is pending
// - start delay: gated ok, continuous faulty
// - startup: gated ok for 800us, continuous faulty until valid
// - valid only after debounce inside window
// - debounced excursion flags fault both modes
// - voltage ramp: gated 800us grace, continuous faulty
// - shutdown, ramp-down, discharge count acceptable
// - pending short flag forces fault
// - thermal or overvoltage flag forces fault
// - undervoltage lockout drives power-good low
// - output active only when no fault present
// - output from fault bits and top flags
// - buck limit 20us sets flag, interrupt low
// - live current-limit status readable
// - no buck limit flag during start or ramp
// - buck below 350mV disables, sets short flag
// - boost limit 64us sets flag, interrupt low
// - boost 150mV below input disables after 1ms
// - boost at 2.5V stops, 1ms later flagged
// - negative limit sets no flag
// - fault bits latched until written one
`timescale 1ns/1ps
`include "pgm_consts.vh"
module pgm_monitor (
   // clock and reset
   input wire CORE_CLK,
   input wire RESET_N,
   // apb slave
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output wire PREADY,
   output wire PSLVERR,
   output reg [31:0] PRDATA,
   // device state and supply
   input wire STANDBY_REACHED,
   input wire UVLO_ACTIVE,
   input wire THERMAL_SD_EVENT,
   input wire INPUT_OVP_EVENT,
   input wire REG_RESET_EVENT,
   // per rail, bit0 buck1, bit1 buck2, bit2 boost
   input wire [2:0] RAIL_ENABLE_PIN,
   input wire [2:0] START_DELAY_ACTIVE,
   input wire [2:0] STARTUP_ACTIVE,
   input wire [2:0] VOLT_RAMP_ACTIVE,
   input wire [2:0] SHUTDOWN_ACTIVE,
   input wire [2:0] RAIL_IN_WINDOW,
   input wire [2:0] PEAK_LIMIT_ACTIVE,
   input wire [2:0] NEG_LIMIT_ACTIVE,
   input wire [1:0] BUCK_BELOW_350MV,
   input wire BOOST_BELOW_INPUT,
   input wire BOOST_BELOW_2V5,
   // outputs
   output reg [1:0] POWER_GOOD_OUTPUT,
   output reg INTERRUPT_OUT_N,
   output reg [2:0] RAIL_DISABLE,
   output reg BOOST_SWITCH_STOP
);
   ////////////////////////////////////////////////////////////////////////////
   // registers
   // ctrl: [2:0] buck/boost enable bits, [5:3] pin control, [8:6] select pg0,
   // [11:9] select pg1, [12] mode pg0, [13] mode pg1
   reg [15:0] ctrl_reg;
   reg [`PGM_NFLAG-1:0] flag_reg;
   wire [`PGM_NFLAG-1:0] flag_next;
   reg [5:0] pgf_reg;
   wire [5:0] pgf_next;
   wire wr = PSEL && PENABLE && PWRITE;
   wire [2:0] en_bit = ctrl_reg[2:0];
   wire [2:0] pin_ctl = ctrl_reg[5:3];
   wire [5:0] sel = ctrl_reg[11:6];
   wire [1:0] mode = ctrl_reg[13:12];
   wire addr_ok = (PADDR == `PGM_A_CTRL) || (PADDR == `PGM_A_FLAGS) ||
                  (PADDR == `PGM_A_STAT) || (PADDR == `PGM_A_PGF);
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !addr_ok;
   ////////////////////////////////////////////////////////////////////////////
   // qualification timers
   wire [2:0] gate_done;
   wire [2:0] valid_q;
   wire [2:0] excur_q;
   wire [2:0] ilim_q;
   wire [1:0] bsc_q;
   wire bst_low_q;
   wire bst_2v5_q;
   wire [2:0] rail_on;
   genvar g;
   generate
      for (g = 0; g < `PGM_NRAIL; g = g + 1) begin : rail
         // gate window spans start-up and ramp; it restarts with each ramp
         pgm_timer #(.LIMIT(`PGM_GATE_CYC)) u_gate (
            .CORE_CLK(CORE_CLK),
            .RESET_N(RESET_N),
            .COND(STARTUP_ACTIVE[g] || VOLT_RAMP_ACTIVE[g]),
            .DONE(gate_done[g])
         );
         pgm_timer #(.LIMIT(`PGM_DEB_CYC)) u_valid (
            .CORE_CLK(CORE_CLK),
            .RESET_N(RESET_N),
            .COND(RAIL_IN_WINDOW[g]),
            .DONE(valid_q[g])
         );
         pgm_timer #(.LIMIT(`PGM_DEB_CYC)) u_excur (
            .CORE_CLK(CORE_CLK),
            .RESET_N(RESET_N),
            .COND(!RAIL_IN_WINDOW[g]),
            .DONE(excur_q[g])
         );
         // the negative limit input is only observed, never counted
         pgm_timer #(.LIMIT((g == 2) ? `PGM_BOOST_CURRENT_LIMIT_SETTING_CYC : `PGM_BUCK_ILIM_CYC)) u_ilim (
            .CORE_CLK(CORE_CLK),
            .RESET_N(RESET_N),
            .COND(PEAK_LIMIT_ACTIVE[g] && rail_on[g]),
            .DONE(ilim_q[g])
         );
         assign rail_on[g] = pin_ctl[g] ? RAIL_ENABLE_PIN[g] : en_bit[g];
      end
      for (g = 0; g < 2; g = g + 1) begin : buck
         pgm_timer #(.LIMIT(`PGM_QUAL_CYC)) u_sc (
            .CORE_CLK(CORE_CLK),
            .RESET_N(RESET_N),
            .COND(BUCK_BELOW_350MV[g] && rail_on[g]),
            .DONE(bsc_q[g])
         );
      end
   endgenerate
   pgm_timer #(.LIMIT(`PGM_QUAL_CYC)) u_bst_low (
      .CORE_CLK(CORE_CLK),
      .RESET_N(RESET_N),
      .COND(BOOST_BELOW_INPUT && rail_on[2]),
      .DONE(bst_low_q)
   );
   pgm_timer #(.LIMIT(`PGM_QUAL_CYC)) u_bst_2v5 (
      .CORE_CLK(CORE_CLK),
      .RESET_N(RESET_N),
      .COND(BOOST_SWITCH_STOP),
      .DONE(bst_2v5_q)
   );
   ////////////////////////////////////////////////////////////////////////////
   // rail fault evaluation, one entry per output and rail
   // entry e covers rail e mod 3 as seen by output e / 3
   wire [5:0] faulty_condition;
   genvar e;
   generate
      for (e = 0; e < 2 * `PGM_NRAIL; e = e + 1) begin : pgsrc
         localparam integer RI = e % `PGM_NRAIL;
         localparam integer PI = e / `PGM_NRAIL;
         wire watched;
         wire short_pending;
         wire rail_idle;
         wire late;
         reg bad;
         assign watched = sel[e];
         assign short_pending = flag_reg[RI];
         // host or pin disable, shutdown delay, ramp-down and discharge all
         // look alike here: the rail is on its way out
         assign rail_idle = !rail_on[RI] || SHUTDOWN_ACTIVE[RI] || RAIL_DISABLE[RI];
         // gated grace ends once the window is over and the rail is still invalid
         assign late = gate_done[RI] && !valid_q[RI];
         always @* begin
            bad = 1'b0;
            if (!watched) begin
               bad = 1'b0;
            end else if (short_pending) begin
               bad = 1'b1;
            end else if (rail_idle) begin
               bad = 1'b0;
            end else if (START_DELAY_ACTIVE[RI]) begin
               bad = mode[PI];
            end else if (VOLT_RAMP_ACTIVE[RI]) begin
               // continuous mode reports the whole ramp as faulty
               bad = mode[PI] ? 1'b1 : late;
            end else if (STARTUP_ACTIVE[RI]) begin
               bad = mode[PI] ? !valid_q[RI] : late;
            end else begin
               bad = excur_q[RI];
            end
         end
         assign faulty_condition[e] = bad;
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////////
   // sticky flags; a set in the same cycle as a write-one clear wins
   wire ctrl_wr = wr && (PADDR == `PGM_A_CTRL);
   wire flags_wr = wr && (PADDR == `PGM_A_FLAGS);
   wire pgf_wr = wr && (PADDR == `PGM_A_PGF);
   wire [2:0] ilim_set;
   wire [`PGM_NFLAG-1:0] flag_set;
   // limit timers keep counting through start-up and ramps, so a limit that
   // outlasts the ramp is flagged on the first cycle after it
   assign ilim_set = ilim_q & ~(STARTUP_ACTIVE | VOLT_RAMP_ACTIVE);
   assign flag_set[`PGM_F_B1SC] = bsc_q[0];
   assign flag_set[`PGM_F_B2SC] = bsc_q[1];
   assign flag_set[`PGM_F_BSTSC] = bst_low_q || bst_2v5_q;
   assign flag_set[`PGM_F_B1IL] = ilim_set[0];
   assign flag_set[`PGM_F_B2IL] = ilim_set[1];
   assign flag_set[`PGM_F_BSTIL] = ilim_set[2];
   // thermal and overvoltage cannot clear while the event persists
   assign flag_set[`PGM_F_TSD] = THERMAL_SD_EVENT;
   assign flag_set[`PGM_F_OVP] = INPUT_OVP_EVENT;
   assign flag_set[`PGM_F_RST] = REG_RESET_EVENT;
   genvar f;
   generate
      for (f = 0; f < `PGM_NFLAG; f = f + 1) begin : sticky
         // write one to clear
         assign flag_next[f] = flag_set[f] || (flag_reg[f] && !(flags_wr && PWDATA[f]));
      end
      for (f = 0; f < 2 * `PGM_NRAIL; f = f + 1) begin : pgfault
         // fault bits latch until written one
         assign pgf_next[f] = faulty_condition[f] || (pgf_reg[f] && !(pgf_wr && PWDATA[f]));
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////////
   // power-good, interrupt and rail control next values
   // thermal, overvoltage and the register-reset flag hold both outputs off
   wire pg_block;
   wire [1:0] pg_next;
   wire int_n_next;
   wire [2:0] rdis_next;
   assign pg_block = !STANDBY_REACHED || UVLO_ACTIVE ||
      flag_next[`PGM_F_TSD] || flag_next[`PGM_F_OVP] ||
      flag_next[`PGM_F_RST];
   genvar o;
   generate
      for (o = 0; o < 2; o = o + 1) begin : pgout
         // any latched fault bit of this output keeps it inactive
         assign pg_next[o] = !pg_block && (pgf_next[o*`PGM_NRAIL +: `PGM_NRAIL] == 3'h0);
      end
   endgenerate
   assign int_n_next = (flag_next == {`PGM_NFLAG{1'b0}});
   // short flags hold the rail off; clearing lets it retry
   assign rdis_next = flag_next[2:0] | {3{flag_next[`PGM_F_TSD] | flag_next[`PGM_F_OVP]}};
   ////////////////////////////////////////////////////////////////////////////
   // read data, captured in the setup cycle of a read
   wire rd_setup = PSEL && !PENABLE && !PWRITE;
   reg [31:0] prdata_next;
   always @* begin
      prdata_next = PRDATA;
      if (rd_setup) begin
         case (PADDR)
            `PGM_A_CTRL: begin
               prdata_next = {16'h0000, ctrl_reg};
            end
            `PGM_A_FLAGS: begin
               prdata_next = {23'h000000, flag_reg};
            end
            `PGM_A_STAT: begin
               // live limit status bits
               prdata_next = {26'h0000000, NEG_LIMIT_ACTIVE, PEAK_LIMIT_ACTIVE};
            end
            `PGM_A_PGF: begin
               prdata_next = {26'h0000000, pgf_reg};
            end
            default: begin
               prdata_next = 32'h00000000;
            end
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // clocked state
   always @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         ctrl_reg <= `PGM_CTRL_RST;
      end else if (ctrl_wr) begin
         ctrl_reg <= PWDATA[15:0];
      end
   end
   always @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         flag_reg <= {`PGM_NFLAG{1'b0}};
         pgf_reg <= 6'h00;
      end else begin
         flag_reg <= flag_next;
         pgf_reg <= pgf_next;
      end
   end
   // rail control outputs
   always @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         RAIL_DISABLE <= 3'h0;
         BOOST_SWITCH_STOP <= 1'b0;
      end else begin
         RAIL_DISABLE <= rdis_next;
         BOOST_SWITCH_STOP <= rail_on[2] && BOOST_BELOW_2V5;
      end
   end
   // status outputs follow the next flag state, one edge after the cause
   always @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         POWER_GOOD_OUTPUT <= 2'h0;
         INTERRUPT_OUT_N <= 1'b1;
      end else begin
         POWER_GOOD_OUTPUT <= pg_next;
         INTERRUPT_OUT_N <= int_n_next;
      end
   end
   always @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         PRDATA <= 32'h00000000;
      end else begin
         PRDATA <= prdata_next;
      end
   end
endmodule

//--- bench/pgm_monitor_checker.sv
// checker for the power-good and overload monitor
`timescale 1ns/1ps
`include "pgm_consts.vh"
module pgm_monitor_checker (
   // causes
   input wire CORE_CLK, input wire RESET_N, input wire STANDBY_REACHED,
   input wire UVLO_ACTIVE, input wire THERMAL_SD_EVENT, input wire INPUT_OVP_EVENT,
   input wire REG_RESET_EVENT, input wire BOOST_BELOW_2V5, input wire [2:0] STARTUP_ACTIVE,
   input wire [2:0] VOLT_RAMP_ACTIVE, input wire [2:0] PEAK_LIMIT_ACTIVE,
   // results
   input wire [1:0] POWER_GOOD_OUTPUT, input wire INTERRUPT_OUT_N, input wire BOOST_SWITCH_STOP
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   // limit counters restart when the qualifier drops; saturate so they never wrap
   reg [10:0] bk_reg;
   reg [10:0] bs_reg;
   wire [2:0] q = PEAK_LIMIT_ACTIVE & ~STARTUP_ACTIVE & ~VOLT_RAMP_ACTIVE;
   wire pg_off = POWER_GOOD_OUTPUT == 2'b00;
   always @(posedge CORE_CLK) begin
      bk_reg <= (!RESET_N || !q[0]) ? 11'h000 : bk_reg + {10'h000, ~&bk_reg};
      bs_reg <= (!RESET_N || !q[2]) ? 11'h000 : bs_reg + {10'h000, ~&bs_reg};
   end
   property p_stby; !STANDBY_REACHED |=> pg_off; endproperty
   a_stby: assert property (p_stby) else $error("pg on early");
   property p_uvlo; UVLO_ACTIVE |=> pg_off; endproperty
   a_uvlo: assert property (p_uvlo) else $error("pg on in lockout");
   property p_top; THERMAL_SD_EVENT || INPUT_OVP_EVENT |=> pg_off && !INTERRUPT_OUT_N; endproperty
   a_top: assert property (p_top) else $error("top flag missed");
   property p_rst; REG_RESET_EVENT |=> pg_off ##1 pg_off; endproperty
   a_rst: assert property (p_rst) else $error("reset flag missed");
   property p_rise; $rose(POWER_GOOD_OUTPUT[0]) |-> $past(STANDBY_REACHED) && !$past(UVLO_ACTIVE); endproperty
   a_rise: assert property (p_rise) else $error("pg rose wrongly");
   property p_bk; bk_reg == `PGM_BUCK_ILIM_CYC |-> ##[0:3] !INTERRUPT_OUT_N; endproperty
   a_bk: assert property (p_bk) else $error("buck limit missed");
   property p_bs; bs_reg == `PGM_BOOST_CURRENT_LIMIT_SETTING_CYC |-> ##[0:3] !INTERRUPT_OUT_N; endproperty
   a_bs: assert property (p_bs) else $error("boost limit missed");
   property p_stop; $rose(BOOST_BELOW_2V5) |-> ##[1:2] BOOST_SWITCH_STOP; endproperty
   a_stop: assert property (p_stop) else $error("boost kept switching");
   c_int: cover property ($fell(INTERRUPT_OUT_N));
   c_pg: cover property ($rose(POWER_GOOD_OUTPUT[0]));
   c_stop: cover property (BOOST_SWITCH_STOP);
endmodule
bind pgm_monitor pgm_monitor_checker chk (.*);

//--- bench/pgm_sys_model.sv
// system side: reset logic fed by power good, host interrupt input
`timescale 1ns/1ps
module pgm_sys_model (
   input wire clk, input wire rst_n, input wire [1:0] pg, input wire int_n,
   output reg run, output reg irq
);
   always @(posedge clk) begin
      run <= rst_n & (&pg);
      irq <= rst_n & ~int_n;
   end
endmodule

//--- bench/power_good_and_overload_monitor_test.sv
// bench for the power-good and overload monitor
`timescale 1ns/1ps
`include "pgm_consts.vh"
module power_good_and_overload_monitor_test;
   reg clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   reg stby = 1'b0, uvlo = 1'b0, b25 = 1'b0, er;
   reg [11:0] pa = 12'h000;
   reg [31:0] pd = 32'h0, rd;
   reg [2:0] ev = 3'h0, sd = 3'h0, su = 3'h0, win = 3'h0, pk = 3'h0, ng = 3'h0;
   reg [2:0] vr = 3'h0, sh = 3'h0, pin = 3'h0;
   reg [1:0] b350 = 2'h0;
   reg bli = 1'b0;
   wire [2:0] rdis;
   reg [16:0] seed = 17'h1228d;
   wire rdy, err, intn, bstop, irq;
   wire [31:0] prd;
   wire [1:0] pg;
   integer fail_count = 0, checks = 0, i;
   pgm_monitor dut (.CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(pa), .PWDATA(pd), .PREADY(rdy), .PSLVERR(err), .PRDATA(prd), .STANDBY_REACHED(stby),
      .UVLO_ACTIVE(uvlo), .THERMAL_SD_EVENT(ev[0]), .INPUT_OVP_EVENT(ev[1]),
      .REG_RESET_EVENT(ev[2]), .RAIL_ENABLE_PIN(pin), .START_DELAY_ACTIVE(sd),
      .STARTUP_ACTIVE(su), .VOLT_RAMP_ACTIVE(vr), .SHUTDOWN_ACTIVE(sh),
      .RAIL_IN_WINDOW(win), .PEAK_LIMIT_ACTIVE(pk), .NEG_LIMIT_ACTIVE(ng),
      .BUCK_BELOW_350MV(b350), .BOOST_BELOW_INPUT(bli), .BOOST_BELOW_2V5(b25),
      .POWER_GOOD_OUTPUT(pg), .INTERRUPT_OUT_N(intn), .RAIL_DISABLE(rdis),
      .BOOST_SWITCH_STOP(bstop));
   pgm_sys_model sys (.clk(clk), .rst_n(rst_n), .pg(pg), .int_n(intn), .run(), .irq(irq));
   initial forever #25 clk = ~clk;
   function [16:0] lfsr(input [16:0] s);
      lfsr = {s[15:0], s[16] ^ s[13]};
   endfunction
   function [31:0] exp_stat(input [2:0] p, input [2:0] n);
      exp_stat = {26'h0, n, p};
   endfunction
   task step(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task cmp(input [31:0] got, input [31:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   // outputs read right after an edge still show the settled pre-edge value
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge clk);
         psel <= 1'b1;
         pwr <= w;
         pa <= a;
         pd <= d;
         @(posedge clk);
         pen <= 1'b1;
         do @(posedge clk); while (rdy !== 1'b1);
         rd = prd;
         er = err;
         psel <= 1'b0;
         pen <= 1'b0;
      end
   endtask
   task clr;
      begin
         apb(1'b1, `PGM_A_FLAGS, 32'hffffffff);
         apb(1'b1, `PGM_A_PGF, 32'hffffffff);
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d fail_count %0d", checks, fail_count);
         if (fail_count == 0 && checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial begin
      step(95000);
      fail_count = fail_count + 1;
      wrap_up;
   end
   initial begin
      step(12);
      rst_n <= 1'b1;
      apb(1'b0, `PGM_A_CTRL, 32'h0);
      cmp({rd[28:0], intn, pg}, 32'h4);
      // pg0 watches all rails gated, pg1 watches buck1 continuous
      apb(1'b1, `PGM_A_CTRL, 32'h000023c7);
      win <= 3'h7;
      step(50);
      cmp(pg, 2'h0);
      stby <= 1'b1;
      step(30);
      clr;
      step(30);
      cmp({pg, irq}, 3'h6);
      sd <= 3'h1;
      step(5);
      cmp(pg, 2'h1);
      sd <= 3'h0;
      step(30);
      apb(1'b0, `PGM_A_PGF, 32'h0);
      cmp({rd[5:3], pg}, 5'h5);
      su <= 3'h1;
      win <= 3'h6;
      step(15900);
      cmp(pg, 2'h1);
      step(200);
      cmp(pg, 2'h0);
      win <= 3'h7;
      pk <= 3'h5;
      step(500);
      cmp(intn, 1'b1);
      su <= 3'h0;
      step(420);
      apb(1'b0, `PGM_A_FLAGS, 32'h0);
      cmp({rd[5:3], irq}, 4'h3);
      step(900);
      apb(1'b0, `PGM_A_FLAGS, 32'h0);
      cmp(rd[5:3], 3'h5);
      pk <= 3'h0;
      ng <= 3'h7;
      clr;
      step(2000);
      cmp({pg, intn}, 3'h7);
      for (i = 0; i < 6; i = i + 1) begin
         seed = lfsr(seed);
         pk <= seed[2:0];
         ng <= seed[5:3];
         apb(1'b0, `PGM_A_STAT, 32'h0);
         cmp(rd, exp_stat(seed[2:0], seed[5:3]));
      end
      pk <= 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
         ev <= 3'h1 << i;
         step(2);
         ev <= 3'h0;
         step(2);
         cmp({pg, intn}, 3'h0);
         apb(1'b0, `PGM_A_FLAGS, 32'h0);
         cmp(rd[8:6], 3'h1 << i);
         clr;
         step(30);
         cmp(pg, 2'h3);
      end
      // ramps: gated grace on both bucks, continuous fault on buck1
      vr <= 3'h3;
      win <= 3'h5;
      step(100);
      cmp(pg, 2'h1);
      step(16000);
      cmp(pg, 2'h0);
      vr <= 3'h0;
      win <= 3'h7;
      step(30);
      clr;
      step(30);
      cmp(pg, 2'h3);
      sh <= 3'h2;
      win <= 3'h5;
      step(50);
      cmp(pg, 2'h3);
      // buck2 under pin control with its pin low
      apb(1'b1, `PGM_A_CTRL, 32'h000023d7);
      sh <= 3'h0;
      step(50);
      cmp(pg, 2'h3);
      pin <= 3'h2;
      step(50);
      cmp(pg, 2'h2);
      pin <= 3'h0;
      win <= 3'h7;
      apb(1'b1, `PGM_A_CTRL, 32'h000023c7);
      clr;
      step(30);
      cmp(pg, 2'h3);
      b350 <= 2'h2;
      bli <= 1'b1;
      step(20005);
      cmp({rdis, pg, intn}, 6'h34);
      b350 <= 2'h0;
      bli <= 1'b0;
      clr;
      step(30);
      cmp({rdis, pg, intn}, 6'h07);
      uvlo <= 1'b1;
      b25 <= 1'b1;
      step(3);
      cmp({pg, bstop}, 3'h1);
      uvlo <= 1'b0;
      step(20005);
      cmp({rdis, intn}, 4'h8);
      b25 <= 1'b0;
      clr;
      apb(1'b0, 12'h010, 32'h0);
      cmp({rd[30:0], er}, 32'h1);
      wrap_up;
   end
endmodule
